// file: design/crc_engine_params.svh
// Constants for the byte stream CRC engine
// Summary of operation
// - Each software byte write to the byte input is one CRC step, unless an init strobe comes in the same cycle
// - Two result widths: 16-bit and 32-bit polynomial
// - Result is internal, reached only through byte pointer and data port
// - Separate bit-reversal register reorders the bits of a byte
// - 16-bit mode is MSB first with polynomial 0x1021
// - 16-bit: byte XORed into upper eight bits of current result
// - 16-bit: eight steps of left shift, XOR polynomial when top bit set
// - 32-bit mode is reflected CRC with polynomial 0x04C11DB7
// - 32-bit: byte XORed into least significant result byte
// - 32-bit: eight steps of right shift, XOR 0xEDB88320 when bottom bit set
// - Result updates automatically after every input byte not met by an init strobe, no start command
// - Width select 0 chooses 32-bit, 1 chooses 16-bit
// - Init strobe loads whole result with value chosen by init select
// - Pointer advances by one after each accepted data port read or write, unless ptr_load loads it in that cycle
`ifndef CRC_ENGINE_PARAMS_SVH
`define CRC_ENGINE_PARAMS_SVH
`define CRC_POLY16      16'h1021
`define CRC_POLY32_REFL 32'hedb88320
`define CRC_INIT_ONES   32'hffffffff
`define CRC_INIT_ZEROS  32'h00000000
`define CRC_BITS_PER_IN 8
`define CRC_SEL_32      1'h0
`define CRC_SEL_16      1'h1
`define CRC_RST_RESULT  32'h00000000
`define CRC_RST_PTR     2'h0
`define CRC_RST_BYTE    8'h00
`define CRC_RST_COUNT   2'h0
`endif

// file: design/crc_engine_pkg.sv
// Types for the byte stream CRC engine
package crc_engine_pkg;
  typedef logic [31:0] result_t;
  typedef logic [7:0]  byte_t;
  typedef logic [1:0]  ptr_t;
endpackage

// file: design/crc_engine.sv
// Byte stream CRC engine with indirect result access and bit reversal
`timescale 1ns/1ps
`include "crc_engine_params.svh"
module crc_engine
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  in_valid,
  output      logic                  in_ready,
  input  wire crc_engine_pkg::byte_t crc_byte_input,
  input  wire logic                  poly_width_select,
  input  wire logic                  init_value_select,
  input  wire logic                  result_init_strobe,
  input  wire logic                  ptr_load,
  input  wire crc_engine_pkg::ptr_t  ptr_load_value,
  output      crc_engine_pkg::ptr_t  result_byte_pointer,
  input  wire logic                  data_write,
  input  wire crc_engine_pkg::byte_t data_write_value,
  input  wire logic                  data_read,
  output      crc_engine_pkg::byte_t result_data_port,
  output      logic                  rd_valid,
  input  wire logic                  rd_ready,
  input  wire crc_engine_pkg::byte_t flip_write_value,
  input  wire logic                  flip_write,
  output      crc_engine_pkg::byte_t flip_read_value
);
  crc_engine_pkg::result_t result_r;
  crc_engine_pkg::result_t result_nxt;
  crc_engine_pkg::ptr_t    ptr_r;
  crc_engine_pkg::ptr_t    ptr_nxt;
  crc_engine_pkg::byte_t   flip_r;
  crc_engine_pkg::byte_t   flip_nxt;
  crc_engine_pkg::byte_t   buf_r [2];
  crc_engine_pkg::byte_t   buf_nxt [2];
  logic [1:0]              cnt_r;
  logic [1:0]              cnt_nxt;
  logic                    rd_take;
  logic                    wr_take;
  logic                    access;
  crc_engine_pkg::byte_t   cur_byte;
  crc_engine_pkg::byte_t   rev_byte;

  function automatic crc_engine_pkg::result_t crc_step(input crc_engine_pkg::result_t acc_in,
                                                       input crc_engine_pkg::byte_t   din,
                                                       input logic                    sel16);
    crc_engine_pkg::result_t acc;
    logic [15:0]             a16;
    acc = acc_in;
    a16 = acc_in[15:0] ^ {din, 8'h00};
    acc = acc ^ {24'h000000, din};
    for (int i = 0; i < `CRC_BITS_PER_IN; i++)
    begin
      if (a16[15])
        a16 = {a16[14:0], 1'h0} ^ `CRC_POLY16;
      else
        a16 = {a16[14:0], 1'h0};
      if (acc[0])
        acc = {1'b0, acc[31:1]} ^ `CRC_POLY32_REFL;
      else
        acc = {1'b0, acc[31:1]};
    end
    if (sel16 == `CRC_SEL_16)
      crc_step = {16'h0000, a16};
    else
      crc_step = acc;
  endfunction

  // Reads go through a two-entry buffer so a stalled reader loses no byte
  assign in_ready = 1'h1;
  assign rd_take  = data_read && (cnt_r != 2'h2);
  assign wr_take  = data_write && !rd_take;
  assign access   = rd_take || wr_take;
  assign rd_valid = (cnt_r != 2'h0);
  assign result_data_port = buf_r[0];
  assign result_byte_pointer = ptr_r;
  assign flip_read_value = flip_r;

  always_comb
  begin
    cur_byte = result_r[ptr_r*8 +: 8];
    if ((poly_width_select == `CRC_SEL_16) && ptr_r[1])
      cur_byte = 8'h00;
  end

  // One wire per bit, so the reversal costs no logic at all
  for (genvar g = 0; g < 8; g++)
  begin
    assign rev_byte[g] = flip_write_value[7 - g];
  end

  always_comb
  begin
    result_nxt = result_r;
    ptr_nxt    = ptr_r;
    // Init wins over a data byte arriving in the same cycle
    if (result_init_strobe)
      result_nxt = init_value_select ? `CRC_INIT_ONES : `CRC_INIT_ZEROS;
    else if (in_valid)
      result_nxt = crc_step(result_r, crc_byte_input, poly_width_select);
    else if (wr_take && !(poly_width_select == `CRC_SEL_16 && ptr_r[1]))
      result_nxt[ptr_r*8 +: 8] = data_write_value;
    if (ptr_load)
      ptr_nxt = ptr_load_value;
    else if (access)
      ptr_nxt = ptr_r + 2'h1;
  end

  always_comb
  begin
    flip_nxt = flip_r;
    if (flip_write)
      flip_nxt = rev_byte;
  end

  always_comb
  begin
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    if (rd_valid && rd_ready)
    begin
      buf_nxt[0] = buf_r[1];
      cnt_nxt = cnt_r - 2'h1;
    end
    if (rd_take)
    begin
      buf_nxt[cnt_nxt[0]] = cur_byte;
      cnt_nxt = cnt_nxt + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result_r <= `CRC_RST_RESULT;
      ptr_r    <= `CRC_RST_PTR;
    end
    else
    begin
      result_r <= result_nxt;
      ptr_r    <= ptr_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flip_r <= `CRC_RST_BYTE;
    else
      flip_r <= flip_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      buf_r <= '{`CRC_RST_BYTE, `CRC_RST_BYTE};
      cnt_r <= `CRC_RST_COUNT;
    end
    else
    begin
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  a_init_load: assert property (@(posedge clk) disable iff (rst)
    result_init_strobe |=> result_r == ($past(init_value_select) ? 32'hffffffff : 32'h0))
    else $error("init value not loaded");
  a_ptr_step: assert property (@(posedge clk) disable iff (rst)
    (access && !ptr_load) |=> ptr_r == $past(ptr_r) + 2'h1)
    else $error("pointer did not advance");
  a_byte_update: assert property (@(posedge clk) disable iff (rst)
    (in_valid && !result_init_strobe) |=>
      result_r == crc_step($past(result_r), $past(crc_byte_input), $past(poly_width_select)))
    else $error("result not updated by byte");
  a_width16_top: assert property (@(posedge clk) disable iff (rst)
    (in_valid && !result_init_strobe && poly_width_select) |=> result_r[31:16] == 16'h0)
    else $error("16-bit result has upper bits");
  a_flip_rev: assert property (@(posedge clk) disable iff (rst)
    flip_write |=> flip_r[7] == $past(flip_write_value[0])
      && flip_r[0] == $past(flip_write_value[7]))
    else $error("bit reversal wrong");
  a_buf_count: assert property (@(posedge clk) disable iff (rst)
    cnt_r != 2'h3)
    else $error("read buffer overflow");
  a_hold_idle: assert property (@(posedge clk) disable iff (rst)
    (!in_valid && !result_init_strobe && !data_write) |=> $stable(result_r))
    else $error("result changed without cause");
  a_ptr_zero: assert property (@(posedge clk) disable iff (rst)
    (rd_take && ptr_r == 2'h0 && cnt_r == 2'h0 && !(rd_valid && rd_ready))
      |=> result_data_port == $past(result_r[7:0]))
    else $error("pointer zero not low byte");

  // Read path: a request into an empty buffer is answered on the next edge
  sequence s_take_empty;
    rd_take && (cnt_r == 2'h0);
  endsequence
  sequence s_head_shown;
    rd_valid;
  endsequence
  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    s_take_empty |=> s_head_shown)
    else $error("read byte not presented");
  a_read_high16: assert property (@(posedge clk) disable iff (rst)
    (rd_take && (cnt_r == 2'h0) && poly_width_select && ptr_r[1])
      |=> result_data_port == 8'h00)
    else $error("16-bit upper byte not zero");
  a_read_refused: assert property (@(posedge clk) disable iff (rst)
    (data_read && (cnt_r == 2'h2) && !data_write && !ptr_load) |=> ptr_r == $past(ptr_r))
    else $error("refused read moved pointer");
  a_write_lands: assert property (@(posedge clk) disable iff (rst)
    (wr_take && !in_valid && !result_init_strobe && !(poly_width_select && ptr_r[1]))
      |=> result_r[$past(ptr_r)*8 +: 8] == $past(data_write_value))
    else $error("data port write lost");
  a_write_drop16: assert property (@(posedge clk) disable iff (rst)
    (wr_take && !in_valid && !result_init_strobe && poly_width_select && ptr_r[1])
      |=> $stable(result_r))
    else $error("16-bit upper byte written");
  // Fixed vectors catch a wrong polynomial or shift direction in the step function
  a_vector16: assert property (@(posedge clk) disable iff (rst)
    (in_valid && !result_init_strobe && poly_width_select && (result_r == 32'hffffffff)
      && (crc_byte_input == 8'h63)) |=> result_r == 32'h0000bd35)
    else $error("16-bit step gives wrong value");
  a_vector32: assert property (@(posedge clk) disable iff (rst)
    (in_valid && !result_init_strobe && !poly_width_select && (result_r == 32'hffffffff)
      && (crc_byte_input == 8'h63)) |=> result_r == 32'hf9462090)
    else $error("32-bit step gives wrong value");
endmodule

// file: verification/tb_byte_stream_crc_engine.sv
// Self-checking testbench for the byte stream CRC engine
`timescale 1ns/1ps
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_byte_stream_crc_engine;
  typedef struct {logic s; logic v; int n; logic [39:0] b; crc_engine_pkg::result_t e;} row_t;
  logic                    clk, rst, in_valid, sel, ival, init_s, ptr_load;
  logic                    data_write, data_read, rd_ready, flip_write, in_ready, rd_valid;
  crc_engine_pkg::byte_t   din, wval, fval, rdata, fout, fe;
  crc_engine_pkg::ptr_t    ptr_v, ptr;
  crc_engine_pkg::result_t r;
  int                      fails, checks;
  row_t                    rows [9];
  crc_engine dut_u (.clk(clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
    .crc_byte_input(din), .poly_width_select(sel), .init_value_select(ival),
    .result_init_strobe(init_s), .ptr_load(ptr_load), .ptr_load_value(ptr_v),
    .result_byte_pointer(ptr), .data_write(data_write), .data_write_value(wval),
    .data_read(data_read), .result_data_port(rdata), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .flip_write_value(fval), .flip_write(flip_write),
    .flip_read_value(fout));
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Inputs always move 5 ns after the edge, so no race with the design's sampling
  task automatic step;
    @(posedge clk);
    #5;
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic init(input logic s, input logic v);
    sel = s;
    ival = v;
    init_s = 1'h1;
    step;
    init_s = 1'h0;
  endtask
  // One read at a time, with a bounded wait for the buffered byte
  task automatic rd_res(output crc_engine_pkg::result_t v);
    int k;
    ptr_load = 1'h1;
    ptr_v = 2'h0;
    step;
    ptr_load = 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      data_read = 1'h1;
      step;
      data_read = 1'h0;
      k = 0;
      while (rd_valid !== 1'h1 && k < 4)
      begin
        step;
        k++;
      end
      if (rd_valid !== 1'h1)
      begin
        fails++;
        end_of_test;
      end
      v[8*i +: 8] = rdata;
      step;
    end
  endtask
  initial
  begin
    {in_valid, sel, ival, init_s, ptr_load, data_write, data_read, flip_write} = '0;
    {din, wval, fval, ptr_v} = '0;
    rst = 1;
    rd_ready = 1;
    fails = 0;
    checks = 0;
    rows = '{'{1, 1, 1, 40'h63, 32'hbd35}, '{1, 1, 1, 40'h8c, 32'hb1f4},
      '{1, 1, 1, 40'h7d, 32'h4eca}, '{1, 1, 5, 40'hccbbaa0000, 32'hb166},
      '{1, 0, 1, 40'h00, 32'h0}, '{0, 1, 0, 40'h00, 32'hffffffff},
      '{0, 1, 1, 40'h63, 32'hf9462090}, '{0, 1, 5, 40'hccbbaa0000, 32'h78d129bc},
      '{0, 1, 3, 40'hccbbaa, 32'h41b207b3}};
    repeat (3) @(posedge clk);
    #5 rst = 0;
    rd_res(r);
    `CMP(r, 32'h0)
    `CMP(ptr, 2'h0)
    $display("test reset done");
    foreach (rows[i])
    begin
      init(rows[i].s, rows[i].v);
      for (int j = 0; j < rows[i].n; j++)
      begin
        in_valid = 1;
        din = rows[i].b[8*j +: 8];
        step;
      end
      in_valid = 0;
      rd_res(r);
      `CMP(r, rows[i].e)
    end
    $display("test rows done");
    // Last row left 41b207b3; a stalled reader must keep both bytes in order
    rd_ready = 0;
    ptr_load = 1;
    step;
    ptr_load = 0;
    data_read = 1;
    repeat (3) step;
    data_read = 0;
    `CMP(ptr, 2'h2)
    `CMP(rdata, 8'hb3)
    rd_ready = 1;
    step;
    `CMP(rdata, 8'h07)
    step;
    `CMP(rd_valid, 1'h0)
    $display("test buffer done");
    for (int s = 0; s < 2; s++)
    begin
      init(s[0], 1'h0);
      ptr_load = 1;
      ptr_v = s[0] ? 2'h2 : 2'h1;
      step;
      ptr_load = 0;
      data_write = 1;
      wval = 8'h5a;
      step;
      data_write = 0;
      `CMP(ptr, s[0] ? 2'h3 : 2'h2)
      rd_res(r);
      `CMP(r, s[0] ? 32'h0 : 32'h5a00)
    end
    $display("test write port done");
    flip_write = 1;
    foreach (rows[i])
    begin
      fval = rows[i].e[7:0];
      fe = {<<{fval}};
      step;
      `CMP(fout, fe)
    end
    flip_write = 0;
    $display("test flip done");
    // Reset in mid-run with a live result, a flipped byte and a byte queued for reading
    rd_ready = 1'h0;
    in_valid = 1'h1;
    din = 8'h63;
    step;
    in_valid = 1'h0;
    data_read = 1'h1;
    step;
    data_read = 1'h0;
    `CMP(rd_valid, 1'h1)
    rst = 1'h1;
    repeat (2) step;
    rst = 1'h0;
    rd_ready = 1'h1;
    `CMP(rd_valid, 1'h0)
    `CMP(rdata, 8'h00)
    `CMP(ptr, 2'h0)
    `CMP(fout, 8'h00)
    `CMP(in_ready, 1'h1)
    rd_res(r);
    `CMP(r, 32'h0)
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule
